// >>> tb/uart_interrupt_enable_status_bench.sv
// Purpose: Self-checking bench for the interrupt core.
// Assumes: AXI4-Lite master with ready signals held high between transfers.
// Notes:   Timeout, pause, wake and clear-to-send are tied low.
`timescale 1ns/1ns
`default_nettype none
`include "uies_defs.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] %0t mismatch %h vs %h", $time, (g), (e)); end end

module uart_interrupt_enable_status_bench;
    logic core_clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, arv = 1'b0, brdy = 1'b1;
    logic rrdy = 1'b1, push = 1'b0, ovr = 1'b0, ferr = 1'b0, tsh = 1'b0, mdl = 1'b0;
    logic [4:0] awaddr = 5'h00, araddr = 5'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic [7:0] d;
    logic [2:0] herr = 3'h0;
    wire awr, wrd, bv, arr, rv, irq, sleep, pop, tpush, tick, rci;
    wire [1:0] bresp;
    wire [31:0] rdata;
    wire [4:0] rxl, txl;
    integer fails = 0, comparisons = 0, seed = 32'h6815bcbe, i, cnt;

    uies_interrupt_core dut_u (.core_clk(core_clk), .rst(rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(brdy), .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdata), .s_axi_rresp(), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
        .rx_level(rxl), .tx_level(txl), .rx_char_in(rci), .rx_overrun(ovr),
        .head_errors(herr), .any_fifo_error(ferr), .rx_timeout(1'b0), .tx_shifter_empty(tsh),
        .modem_delta(mdl), .pause_char_seen(1'b0), .wake_event(1'b0), .clear_to_send_pin(1'b0),
        .rx_pop(pop), .tx_push(tpush), .tx_data(), .modem_stat_read(), .rx_fifo_clear(),
        .tx_fifo_clear(), .sleep_enable(sleep), .request_to_send(), .rate_tick(tick), .irq(irq));
    uies_event_model ev_u (.core_clk(core_clk), .rst(rst), .push(push), .rx_pop(pop),
        .tx_push(tpush), .rate_tick(tick), .rx_level(rxl), .tx_level(txl), .rx_char_in(rci));

    // A 4 ns clock.
    initial
    begin
        forever #2 core_clk = ~core_clk;
    end

    // Status byte is the FIFO flag twice above the six-bit source code.
    function [7:0] stat(input logic f, input logic [5:0] c);
        stat = {f, f, c};
    endfunction

    task complete_run;
    begin
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask

    task tmo(input integer n);
    begin
        if (n >= 64)
        begin
            fails++;
            complete_run;
        end
    end
    endtask

    // Both write halves go out together and drop once taken.
    task wr(input logic [2:0] a, input logic [7:0] v);
        integer n;
    begin
        @(posedge core_clk);
        awaddr <= {a, 2'b00};
        wdata <= {24'h000000, v};
        awv <= 1'b1;
        wv <= 1'b1;
        @(posedge core_clk);
        for (n = 0; awr !== 1'b1 && n < 64; n++) @(posedge core_clk);
        awv <= 1'b0;
        wv <= 1'b0;
        @(posedge core_clk);
        for (n = n; bv !== 1'b1 && n < 64; n++) @(posedge core_clk);
        tmo(n);
    end
    endtask

    task rd(input logic [2:0] a, output logic [7:0] v);
        integer n;
    begin
        @(posedge core_clk);
        araddr <= {a, 2'b00};
        arv <= 1'b1;
        @(posedge core_clk);
        for (n = 0; arr !== 1'b1 && n < 64; n++) @(posedge core_clk);
        arv <= 1'b0;
        @(posedge core_clk);
        for (n = n; rv !== 1'b1 && n < 64; n++) @(posedge core_clk);
        v = rdata[7:0];
        tmo(n);
    end
    endtask

    task rchk(input logic [2:0] a, input logic [7:0] e);
        logic [7:0] v;
    begin
        rd(a, v);
        `CHK(v, e)
    end
    endtask

    // Main sequence; the wait after the first push lets the level reach the status code.
    initial
    begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        rchk(3'h1, 8'h00);
        rchk(3'h2, stat(1'b0, `UIES_CODE_NONE));
        `CHK(irq, 1'b0)
        wr(3'h1, 8'hf0);
        rchk(3'h1, 8'h00);
        wr(3'h2, 8'h01);
        wr(3'h1, 8'h01);
        push <= 1'b1;
        @(posedge core_clk);
        push <= 1'b0;
        repeat (4) @(posedge core_clk);
        rchk(3'h2, stat(1'b1, `UIES_CODE_RXDATA));
        `CHK(irq, 1'b1)
        rd(3'h5, d);
        `CHK(d[0], 1'b1)
        rd(3'h0, d);
        repeat (4) @(posedge core_clk);
        rchk(3'h2, stat(1'b1, `UIES_CODE_NONE));
        rd(3'h5, d);
        `CHK(d[0], 1'b0)
        tsh <= 1'b1;
        ferr <= 1'b1;
        ovr <= 1'b1;
        @(posedge core_clk);
        ovr <= 1'b0;
        wr(3'h1, 8'h04);
        rchk(3'h2, stat(1'b1, `UIES_CODE_LINE));
        rd(3'h5, d);
        `CHK(d[7:5], 3'b111)
        `CHK(d[1], 1'b1)
        wr(3'h1, 8'h06);
        rchk(3'h2, stat(1'b1, `UIES_CODE_TXREADY));
        rchk(3'h2, stat(1'b1, `UIES_CODE_NONE));
        herr <= 3'h4;
        push <= 1'b1;
        @(posedge core_clk);
        push <= 1'b0;
        rchk(3'h2, stat(1'b1, `UIES_CODE_NONE));
        rd(3'h0, d);
        rchk(3'h2, stat(1'b1, `UIES_CODE_LINE));
        rd(3'h5, d);
        `CHK(d[4:2], 3'h4)
        herr <= 3'h0;
        wr(3'h0, 8'h5a);
        repeat (4) @(posedge core_clk);
        rchk(3'h2, stat(1'b1, `UIES_CODE_TXREADY));
        mdl <= 1'b1;
        wr(3'h1, 8'h08);
        rchk(3'h2, stat(1'b1, `UIES_CODE_MODEM));
        wr(3'h1, 8'h00);
        rchk(3'h2, stat(1'b1, `UIES_CODE_NONE));
        `CHK(irq, 1'b0)
        mdl <= 1'b0;
        wr(3'h3, 8'h80);
        wr(3'h0, 8'h03);
        wr(3'h1, 8'h00);
        rchk(3'h0, 8'h03);
        cnt = 0;
        repeat (60)
        begin
            @(posedge core_clk);
            cnt = cnt + (tick === 1'b1);
        end
        `CHK(cnt >= 15 && cnt <= 60 / 3 + 1, 1'b1)
        wr(3'h3, `UIES_FMT_ENH_KEY);
        wr(3'h2, 8'h10);
        rchk(3'h2, 8'h10);
        wr(3'h3, 8'h03);
        for (i = 0; i < 8; i++)
        begin
            cnt = $random(seed);
            d = cnt[7:0];
            wr(3'h1, d);
            rchk(3'h1, d);
            `CHK(sleep, d[4])
        end
        complete_run;
    end
endmodule // uart_interrupt_enable_status_bench

`default_nettype wire

// >>> tb/uies_event_model.sv
// Purpose: Far-side model of the receive and transmit FIFO fill levels.
// Assumes: One character enters per push strobe; the core pops by read strobe.
// Notes:   The transmit side drains one entry per bit-rate tick.
`timescale 1ns/1ns
`default_nettype none

module uies_event_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic push,
    input wire logic rx_pop,
    input wire logic tx_push,
    input wire logic rate_tick,
    output logic [4:0] rx_level,
    output logic [4:0] tx_level,
    output logic rx_char_in
);
    // Levels move by one per strobe; the bench never pushes and pops together.
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            rx_level <= 5'h00;
            tx_level <= 5'h00;
            rx_char_in <= 1'b0;
        end
        else
        begin
            rx_char_in <= push;
            if (push)
                rx_level <= rx_level + 5'h01;
            else if (rx_pop && rx_level != 5'h00)
                rx_level <= rx_level - 5'h01;
            if (tx_push)
                tx_level <= tx_level + 5'h01;
            else if (rate_tick && tx_level != 5'h00)
                tx_level <= tx_level - 5'h01;
        end
    end
endmodule // uies_event_model

`default_nettype wire

// >>> tb/uies_properties.sv
// Purpose: Bus handshake and strobe checks on the core's ports.
// Assumes: Answers one cycle after a request is taken.
// Notes:   Attached by bind; watches signals that the core drives and bus signals that it receives.
`timescale 1ns/1ns
`default_nettype none
`include "uies_defs.vh"

module uies_checker (
    input wire core_clk,
    input wire rst,
    input wire [`UIES_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`UIES_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire rx_pop,
    input wire tx_push
);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_wr_take;
        s_axi_awvalid && s_axi_wvalid && s_axi_awready && s_axi_wready;
    endsequence
    a_write_answer: assert property (s_wr_take |=> s_axi_bvalid && s_axi_bresp == `UIES_AXI_OKAY)
        else $error("write answer missing");
    a_write_pair: assert property (s_axi_awready |-> s_axi_wready && s_axi_wvalid && !s_axi_bvalid)
        else $error("write halves split");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer missing");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data changed");
    a_push_cause: assert property (tx_push |-> $past(s_axi_awvalid && s_axi_awaddr[4:2] == 3'h0))
        else $error("push without holding write");
    a_pop_cause: assert property (rx_pop |-> $past(s_axi_arvalid && s_axi_araddr[4:2] == 3'h0))
        else $error("pop without holding read");
    a_push_pulse: assert property (tx_push |=> !tx_push)
        else $error("push longer than a cycle");
endmodule // uies_checker

bind uies_interrupt_core uies_checker chk_u (.core_clk(core_clk), .rst(rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .rx_pop(rx_pop), .tx_push(tx_push));

`default_nettype wire

// >>> verilog/uies_bit_rate_counter.v
// Purpose: Sixteen-bit divisor counter that sets the transmitter bit rate.
// Assumes: A divisor of zero is treated as one so the tick never stops.
// Notes:   The counter reloads when a new divisor is written.
`timescale 1ns/1ns
`default_nettype none

module uies_bit_rate_counter #(
    parameter WIDTH = 16
) (
    input wire core_clk,
    input wire rst,
    input wire [WIDTH-1:0] divisor,
    input wire reload,
    output reg rate_tick
);

reg [WIDTH-1:0] count_reg;

// Count down from the divisor and pulse once each time it reaches one and reloads.
always @(posedge core_clk or posedge rst)
begin
    if (rst)
    begin
        count_reg <= {WIDTH{1'b0}};
        rate_tick <= 1'b0;
    end
    else if (reload || count_reg <= {{(WIDTH-1){1'b0}}, 1'b1})
    begin
        count_reg <= divisor;
        rate_tick <= ~reload;
    end
    else
    begin
        count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
        rate_tick <= 1'b0;
    end
end

endmodule // uies_bit_rate_counter
`default_nettype wire

// >>> verilog/uies_defs.vh
// Purpose: Register offsets, field positions, source codes, reset values and bus response codes for the block.
// Assumes: Every register takes one aligned 32-bit word on the AXI4-Lite bus.
// Notes:   Byte offsets are four times the register index.
`ifndef UIES_DEFS_VH
`define UIES_DEFS_VH

// ----------------------------------------------------------------------------
// Register indices and bus address width.
// ----------------------------------------------------------------------------
`define UIES_IDX_HOLD         3'h0
`define UIES_IDX_MASK         3'h1
`define UIES_IDX_STATUS       3'h2
`define UIES_IDX_FORMAT       3'h3
`define UIES_IDX_MODEM        3'h4
`define UIES_IDX_LINE         3'h5
`define UIES_IDX_MODEM_STAT   3'h6
`define UIES_IDX_SCRATCH      3'h7
`define UIES_IDX_FEATURE      3'h2
`define UIES_IDX_RESUME1      3'h4
`define UIES_IDX_RESUME2      3'h5
`define UIES_IDX_PAUSE1       3'h6
`define UIES_IDX_PAUSE2       3'h7
`define UIES_ADDR_W           5

// ----------------------------------------------------------------------------
// Field positions and codes.
// ----------------------------------------------------------------------------
`define UIES_FEAT_ENH_BIT     4
`define UIES_FMT_DIV_BIT      7
`define UIES_FMT_ENH_KEY      8'hbf
`define UIES_SETUP_EN_BIT     0
`define UIES_SETUP_RXRST_BIT  1
`define UIES_SETUP_TXRST_BIT  2
`define UIES_CODE_NONE        6'h01
`define UIES_CODE_LINE        6'h06
`define UIES_CODE_TIMEOUT     6'h0c
`define UIES_CODE_RXDATA      6'h04
`define UIES_CODE_TXREADY     6'h02
`define UIES_CODE_MODEM       6'h00
`define UIES_CODE_PAUSE       6'h10
`define UIES_CODE_HSHAKE      6'h20
`define UIES_RESET_BYTE       8'h00
`define UIES_RESET_DIV        16'h0001
`define UIES_AXI_OKAY         2'h0
`define UIES_AXI_SLVERR       2'h2

`endif

// >>> verilog/uies_interrupt_core.v
// Purpose: Interrupt mask, interrupt source status and line condition status of a UART.
// Assumes: FIFOs, receiver and modem logic sit outside and report levels and pulses.
// Notes:   Registers sit behind an AXI4-Lite slave; one access of each kind at a time.
`timescale 1ns/1ns
`default_nettype none
`include "uies_defs.vh"

module uies_interrupt_core #(
    parameter DIV_WIDTH = 16
) (
    input wire core_clk,
    input wire rst,
    // AXI4-Lite slave.
    input wire [`UIES_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`UIES_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Event sources from FIFOs, receiver and modem logic.
    input wire [4:0] rx_level,
    input wire [4:0] tx_level,
    input wire rx_char_in,
    input wire rx_overrun,
    input wire [2:0] head_errors,
    input wire any_fifo_error,
    input wire rx_timeout,
    input wire tx_shifter_empty,
    input wire modem_delta,
    input wire pause_char_seen,
    input wire wake_event,
    input wire clear_to_send_pin,
    // Strobes and settings to the surrounding logic.
    output reg rx_pop,
    output reg tx_push,
    output reg [7:0] tx_data,
    output reg modem_stat_read,
    output reg rx_fifo_clear,
    output reg tx_fifo_clear,
    output reg sleep_enable,
    output reg request_to_send,
    output wire rate_tick,
    output wire irq
);

// ----------------------------------------------------------------------------
// Register storage.
// ----------------------------------------------------------------------------
reg [7:0] mask_reg;
reg [7:0] feature_reg;
reg [7:0] format_reg;
reg [7:0] modem_reg;
reg [7:0] setup_reg;
reg [7:0] scratch_reg;
reg [7:0] resume1_reg;
reg [7:0] resume2_reg;
reg [7:0] pause1_reg;
reg [7:0] pause2_reg;
reg [DIV_WIDTH-1:0] divisor_reg;
reg div_load_reg;
reg overrun_reg;
reg line_err_reg;
reg tx_ready_reg;
reg hshake_reg;
reg pause_reg;
reg wake_reg;
reg [5:0] held_code_reg;
reg cts_meta_reg;
reg cts_sync_reg;
reg cts_prev_reg;
reg rts_prev_reg;
reg tx_low_prev_reg;

wire enh = feature_reg[`UIES_FEAT_ENH_BIT];
wire fifo_on = setup_reg[`UIES_SETUP_EN_BIT];
wire key_mode = (format_reg == `UIES_FMT_ENH_KEY);
wire div_map = format_reg[`UIES_FMT_DIV_BIT];

// Receive trigger level, decoded from setup bits 7:6.
function [4:0] uies_trig;
    input [1:0] sel;
    begin
        case (sel)
            2'h0: uies_trig = 5'h01;
            2'h1: uies_trig = 5'h04;
            2'h2: uies_trig = 5'h08;
            default: uies_trig = 5'h0e;
        endcase
    end
endfunction

wire [4:0] rx_trig = uies_trig(setup_reg[7:6]);
// Transmit trigger select is held at level 1 unless the extended bits are on.
wire [4:0] tx_trig = uies_trig(enh ? setup_reg[5:4] : 2'h0);

// ----------------------------------------------------------------------------
// Bus handshake.
// ----------------------------------------------------------------------------
// Address and data are taken together only, so the write decode sees both.
wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
wire rd_go = s_axi_arvalid && !s_axi_rvalid;
assign s_axi_awready = wr_go;
assign s_axi_wready = wr_go;
assign s_axi_arready = rd_go;
wire [2:0] w_idx = s_axi_awaddr[4:2];
wire [2:0] r_idx = s_axi_araddr[4:2];
wire w_lane = s_axi_wstrb[0];
wire [7:0] w_byte = s_axi_wdata[7:0];

wire wr_hold = wr_go && w_lane && !div_map && !key_mode && w_idx == `UIES_IDX_HOLD;
wire rd_hold = rd_go && !div_map && !key_mode && r_idx == `UIES_IDX_HOLD;
wire rd_status = rd_go && !key_mode && r_idx == `UIES_IDX_STATUS;
wire rd_line = rd_go && !key_mode && r_idx == `UIES_IDX_LINE;

// ----------------------------------------------------------------------------
// Line condition status.
// ----------------------------------------------------------------------------
wire data_ready = (rx_level != 5'h00);
wire hold_empty = (tx_level == 5'h00);
// Below the trigger in FIFO mode, empty otherwise; its rising edge arms transmit ready.
wire tx_below = tx_level < (fifo_on ? tx_trig : 5'h01);
wire [7:0] line_status =
    {any_fifo_error, hold_empty && tx_shifter_empty, hold_empty,
     head_errors, overrun_reg, data_ready};

// ----------------------------------------------------------------------------
// Source requests, each gated by its mask bit.
// ----------------------------------------------------------------------------
// Head byte errors count only once the byte is popped from the holding position.
wire line_req = mask_reg[2] && (overrun_reg || line_err_reg);
wire rx_req = mask_reg[0] && (fifo_on ? (rx_level >= rx_trig) : data_ready);
wire to_req = mask_reg[0] && fifo_on && rx_timeout;
wire tx_req = mask_reg[1] && tx_ready_reg;
wire mdm_req = mask_reg[3] && modem_delta;
wire pause_req = enh && mask_reg[5] && pause_reg;
wire hs_req = enh && (mask_reg[6] || mask_reg[7]) && hshake_reg;

// Priority encoder of the pending code.
reg [5:0] live_code;
always @*
begin
    if (line_req) live_code = `UIES_CODE_LINE;
    else if (to_req) live_code = `UIES_CODE_TIMEOUT;
    else if (rx_req) live_code = `UIES_CODE_RXDATA;
    else if (tx_req) live_code = `UIES_CODE_TXREADY;
    else if (mdm_req) live_code = `UIES_CODE_MODEM;
    else if (pause_req) live_code = `UIES_CODE_PAUSE;
    else if (hs_req) live_code = `UIES_CODE_HSHAKE;
    else live_code = `UIES_CODE_NONE;
end

// The reported code is latched and only moves once it is no longer pending.
wire held_live = (held_code_reg == `UIES_CODE_LINE) ? line_req :
                 (held_code_reg == `UIES_CODE_TIMEOUT) ? to_req :
                 (held_code_reg == `UIES_CODE_RXDATA) ? rx_req :
                 (held_code_reg == `UIES_CODE_TXREADY) ? tx_req :
                 (held_code_reg == `UIES_CODE_MODEM) ? mdm_req :
                 (held_code_reg == `UIES_CODE_PAUSE) ? pause_req :
                 (held_code_reg == `UIES_CODE_HSHAKE) ? hs_req : 1'b0;
wire [5:0] code_next = held_live ? held_code_reg : live_code;
wire [5:0] shown_code = (code_next == `UIES_CODE_NONE && wake_reg) ?
                        `UIES_CODE_NONE : code_next;
wire [5:0] vis_code = enh ? shown_code : {2'b00, shown_code[3:0]};
wire [7:0] status_byte = {fifo_on, fifo_on, vis_code};

assign irq = (held_code_reg != `UIES_CODE_NONE);

// ----------------------------------------------------------------------------
// Register read multiplexer.
// ----------------------------------------------------------------------------
reg [7:0] rd_byte;
always @*
begin
    rd_byte = 8'h00;
    if (key_mode && r_idx == `UIES_IDX_FEATURE)
        rd_byte = feature_reg;
    else if (div_map && r_idx == `UIES_IDX_HOLD)
        rd_byte = divisor_reg[7:0];
    else if (div_map && r_idx == `UIES_IDX_MASK)
        rd_byte = divisor_reg[15:8];
    else
    begin
        case (r_idx)
            `UIES_IDX_MASK: rd_byte = enh ? mask_reg : {4'h0, mask_reg[3:0]};
            `UIES_IDX_STATUS: rd_byte = status_byte;
            `UIES_IDX_FORMAT: rd_byte = format_reg;
            `UIES_IDX_MODEM: rd_byte = enh ? modem_reg : {3'h0, modem_reg[4:3], 1'b0,
                                                           modem_reg[1:0]};
            `UIES_IDX_LINE: rd_byte = line_status;
            `UIES_IDX_SCRATCH: rd_byte = scratch_reg;
            default: rd_byte = 8'h00;
        endcase
    end
end

// ----------------------------------------------------------------------------
// Bus responses.
// ----------------------------------------------------------------------------
// Answers come one cycle after the request is taken.
always @(posedge core_clk or posedge rst)
begin
    if (rst)
    begin
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `UIES_AXI_OKAY;
        s_axi_rvalid <= 1'b0;
        s_axi_rresp <= `UIES_AXI_OKAY;
        s_axi_rdata <= 32'h00000000;
    end
    else
    begin
        if (wr_go)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `UIES_AXI_OKAY;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
        if (rd_go)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `UIES_AXI_OKAY;
            s_axi_rdata <= {24'h000000, rd_byte};
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
end

// ----------------------------------------------------------------------------
// Register writes and one-cycle strobes.
// ----------------------------------------------------------------------------
always @(posedge core_clk or posedge rst)
begin
    if (rst)
    begin
        mask_reg <= `UIES_RESET_BYTE;
        feature_reg <= `UIES_RESET_BYTE;
        format_reg <= `UIES_RESET_BYTE;
        modem_reg <= `UIES_RESET_BYTE;
        setup_reg <= `UIES_RESET_BYTE;
        scratch_reg <= `UIES_RESET_BYTE;
        resume1_reg <= `UIES_RESET_BYTE;
        resume2_reg <= `UIES_RESET_BYTE;
        pause1_reg <= `UIES_RESET_BYTE;
        pause2_reg <= `UIES_RESET_BYTE;
        divisor_reg <= `UIES_RESET_DIV;
        div_load_reg <= 1'b0;
        tx_push <= 1'b0;
        tx_data <= 8'h00;
        rx_fifo_clear <= 1'b0;
        tx_fifo_clear <= 1'b0;
    end
    else
    begin
        div_load_reg <= 1'b0;
        tx_push <= wr_hold;
        rx_fifo_clear <= 1'b0;
        tx_fifo_clear <= 1'b0;
        if (wr_hold)
            tx_data <= w_byte;
        if (wr_go && w_lane)
        begin
            if (key_mode)
            begin
                case (w_idx)
                    `UIES_IDX_FEATURE: feature_reg <= w_byte;
                    `UIES_IDX_RESUME1: resume1_reg <= w_byte;
                    `UIES_IDX_RESUME2: resume2_reg <= w_byte;
                    `UIES_IDX_PAUSE1: pause1_reg <= w_byte;
                    `UIES_IDX_PAUSE2: pause2_reg <= w_byte;
                    `UIES_IDX_FORMAT: format_reg <= w_byte;
                    default: format_reg <= format_reg;
                endcase
            end
            else if (div_map && w_idx == `UIES_IDX_HOLD)
            begin
                divisor_reg[7:0] <= w_byte;
                div_load_reg <= 1'b1;
            end
            else if (div_map && w_idx == `UIES_IDX_MASK)
            begin
                divisor_reg[15:8] <= w_byte;
                div_load_reg <= 1'b1;
            end
            else
            begin
                case (w_idx)
                    // Upper mask bits keep their value while extended bits are off.
                    `UIES_IDX_MASK: mask_reg <= enh ? w_byte : {mask_reg[7:4], w_byte[3:0]};
                    `UIES_IDX_STATUS:
                    begin
                        // Setup bits other than enable only take with enable set.
                        if (w_byte[`UIES_SETUP_EN_BIT])
                        begin
                            setup_reg <= {w_byte[7:6], enh ? w_byte[5:4] : setup_reg[5:4],
                                          w_byte[3], 3'b001};
                            rx_fifo_clear <= w_byte[`UIES_SETUP_RXRST_BIT];
                            tx_fifo_clear <= w_byte[`UIES_SETUP_TXRST_BIT];
                        end
                        else
                            setup_reg <= {setup_reg[7:1], 1'b0};
                    end
                    `UIES_IDX_FORMAT: format_reg <= w_byte;
                    `UIES_IDX_MODEM: modem_reg <= enh ? w_byte : {modem_reg[7:5], w_byte[4:3],
                                                                  modem_reg[2], w_byte[1:0]};
                    `UIES_IDX_SCRATCH: scratch_reg <= w_byte;
                    default: scratch_reg <= scratch_reg;
                endcase
            end
        end
    end
end

// ----------------------------------------------------------------------------
// Event flags and read side effects.
// ----------------------------------------------------------------------------
// In each flag the set term is tested last so an event in the clearing cycle survives.
always @(posedge core_clk or posedge rst)
begin
    if (rst)
    begin
        overrun_reg <= 1'b0;
        line_err_reg <= 1'b0;
        tx_ready_reg <= 1'b0;
        hshake_reg <= 1'b0;
        pause_reg <= 1'b0;
        wake_reg <= 1'b0;
        held_code_reg <= `UIES_CODE_NONE;
        cts_meta_reg <= 1'b0;
        cts_sync_reg <= 1'b0;
        cts_prev_reg <= 1'b0;
        rts_prev_reg <= 1'b0;
        tx_low_prev_reg <= 1'b1;
        rx_pop <= 1'b0;
        modem_stat_read <= 1'b0;
        sleep_enable <= 1'b0;
        request_to_send <= 1'b0;
    end
    else
    begin
        cts_meta_reg <= clear_to_send_pin;
        cts_sync_reg <= cts_meta_reg;
        cts_prev_reg <= cts_sync_reg;
        rts_prev_reg <= request_to_send;
        tx_low_prev_reg <= tx_below;
        request_to_send <= modem_reg[1];
        sleep_enable <= enh && mask_reg[4];
        rx_pop <= rd_hold;
        modem_stat_read <= rd_go && !key_mode && r_idx == `UIES_IDX_MODEM_STAT;
        held_code_reg <= code_next;
        if (rd_line)
        begin
            overrun_reg <= 1'b0;
            line_err_reg <= 1'b0;
        end
        if (rx_overrun)
            overrun_reg <= 1'b1;
        if (rx_pop && head_errors != 3'h0)
            line_err_reg <= 1'b1;
        if (rd_status || wr_hold)
            tx_ready_reg <= 1'b0;
        // Falling below the trigger or emptying, or a fresh enable while the holding side is empty, arms transmit ready.
        if ((tx_below && !tx_low_prev_reg) ||
            (hold_empty && !tx_push && (tx_level == 5'h00) && !tx_ready_reg && !wr_hold &&
             !rd_status && wr_go && w_idx == `UIES_IDX_MASK && !div_map && !key_mode &&
             w_byte[1] && !mask_reg[1]))
            tx_ready_reg <= 1'b1;
        if (modem_stat_read)
            hshake_reg <= 1'b0;
        if ((mask_reg[6] && request_to_send && !rts_prev_reg) ||
            (mask_reg[7] && cts_sync_reg && !cts_prev_reg))
            hshake_reg <= 1'b1;
        if (rd_status || rx_char_in)
            pause_reg <= 1'b0;
        if (pause_char_seen)
            pause_reg <= 1'b1;
        if (rd_status)
            wake_reg <= 1'b0;
        if (wake_event)
            wake_reg <= 1'b1;
    end
end

// ----------------------------------------------------------------------------
// Bit rate counter.
// ----------------------------------------------------------------------------
uies_bit_rate_counter #(
    .WIDTH(DIV_WIDTH)
) u_rate (
    .core_clk(core_clk),
    .rst(rst),
    .divisor(divisor_reg),
    .reload(div_load_reg),
    .rate_tick(rate_tick)
);

endmodule // uies_interrupt_core
`default_nettype wire
